// ### hw/input_calibration_table_manager.sv
// Calibration command group: mode, save, type, gain and offset handling.
// Assumes a decoded command port and a word-wide flash table port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Entering calibration mode copies the flash table into working RAM.
// - In calibration mode, readings are corrected by RAM coefficients only.
// - Leaving calibration mode never writes flash.
// - Mode command carries a channel field that is ignored.
// - Mode query answers ON or OFF.
// - Outside calibration mode, most commands change nothing.
// - Save writes flash only in calibration mode, else does nothing.
// - Save writes the whole table for every channel.
// - Type set works only in calibration mode; one type per channel.
// - Five types: voltage, current source, three resistance ranges.
// - Type query returns the selected type of the named channel.
// - Gain is a float with nominal value one.
// - Gain kept per channel and type, chosen by selected type.
// - Offset is a signed count, positive or negative.
// - Offset kept per channel and type, chosen by selected type.
module input_calibration_table_manager #(
	parameter int unsigned CHANNELS = 4,
	parameter int unsigned SAMPLE_W = 24,
	parameter int unsigned OFFSET_W = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic [2:0] cmd_code_i,
	input wire logic cmd_query_i,
	input wire logic [1:0] cmd_chan_i,
	input wire logic [31:0] cmd_arg_i,
	output logic resp_valid_o,
	output logic [31:0] resp_data_o,
	output logic cal_mode_o,
	output logic busy_o,
	output logic flash_rd_o,
	output logic flash_wr_o,
	output logic [4:0] flash_addr_o,
	output logic [47:0] flash_wdata_o,
	input wire logic [47:0] flash_rdata_i,
	input wire logic flash_ack_i,
	input wire logic sample_valid_i,
	input wire logic [1:0] sample_chan_i,
	input wire logic signed [SAMPLE_W-1:0] sample_i,
	output logic corr_valid_o,
	output logic signed [SAMPLE_W-1:0] corr_o
);
	localparam int unsigned ENTRIES = CHANNELS * cal_table_pkg::NUM_TYPES;
	initial begin
		if (CHANNELS != cal_table_pkg::NUM_CHANNELS)
			$error("channel count must be four");
		if (OFFSET_W > 16) $error("offset wider than table slot");
	end

	typedef enum logic [1:0] {
		st_idle = 2'h0,
		st_load = 2'h1,
		st_save = 2'h2
	} state_t;

	state_t state, next_state;
	logic cal_mode, next_cal_mode;
	logic [4:0] idx, next_idx;
	logic [31:0] gain_tab [ENTRIES];
	logic [31:0] next_gain_tab [ENTRIES];
	logic [15:0] off_tab [ENTRIES];
	logic [15:0] next_off_tab [ENTRIES];
	logic [2:0] sel_type [CHANNELS];
	logic [2:0] next_sel_type [CHANNELS];
	logic next_resp_valid;
	logic [31:0] next_resp_data;

	// Table index of one channel and type
	function automatic logic [4:0] slot(input logic [1:0] ch,
		input logic [2:0] ty);
		slot = 5'(ch * cal_table_pkg::NUM_TYPES + ty);
	endfunction : slot

	// Gain float to Q2.16; coarse but adequate near the nominal value
	function automatic logic [17:0] gain_q(input logic [31:0] f);
		logic [23:0] mant;
		int sh;
		mant = {1'b1, f[22:0]};
		sh = int'(f[30:23]) - 127;
		if (f[30:23] == 8'h00 || f[31]) gain_q = 18'h00000;
		else if (sh >= 2) gain_q = 18'h3ffff;
		else if (sh >= 0) gain_q = 18'(mant >> (7 - sh));
		else if (sh >= -16) gain_q = 18'(mant >> (7 - sh));
		else gain_q = 18'h00000;
	endfunction : gain_q

	logic [4:0] cmd_slot;
	logic [4:0] smp_slot;
	logic cmd_fire;
	assign cmd_ready_o = (state == st_idle);
	assign cmd_fire = cmd_valid_i && cmd_ready_o;
	assign cmd_slot = slot(cmd_chan_i, sel_type[cmd_chan_i]);
	// selected type steers the table slot
	assign smp_slot = slot(sample_chan_i, sel_type[sample_chan_i]);

	// Command interpreter and table copy sequencer
	always_comb begin
		next_state = state;
		next_cal_mode = cal_mode;
		next_idx = idx;
		next_gain_tab = gain_tab;
		next_off_tab = off_tab;
		next_sel_type = sel_type;
		next_resp_valid = 1'b0;
		next_resp_data = resp_data_o;
		case (state)
			st_idle: begin
				if (cmd_fire) begin
					case (cmd_code_i)
						cal_table_pkg::cmd_mode: begin
							// Channel field not decoded
							if (cmd_query_i) begin
								next_resp_valid = 1'b1;
								next_resp_data = {31'h0, cal_mode};
							end else if (cmd_arg_i[0] && !cal_mode) begin
								next_state = st_load;
								next_idx = 5'h00;
							end else if (!cmd_arg_i[0]) begin
								next_cal_mode = 1'b0; // No flash write
							end
						end
						cal_table_pkg::cmd_save: begin
							// Silently dropped outside the mode
							if (cal_mode) begin
								next_state = st_save; // Whole table
								next_idx = 5'h00;
							end
						end
						cal_table_pkg::cmd_type: begin
							if (cmd_query_i) begin
								next_resp_valid = 1'b1;
								next_resp_data = {29'h0, sel_type[cmd_chan_i]};
							end else if (cal_mode &&
								cmd_arg_i < 32'(cal_table_pkg::NUM_TYPES)) begin
								next_sel_type[cmd_chan_i] = cmd_arg_i[2:0];
							end
						end
						cal_table_pkg::cmd_gain: begin
							if (cmd_query_i) begin
								next_resp_valid = 1'b1;
								next_resp_data = gain_tab[cmd_slot];
							end else if (cal_mode) begin
								next_gain_tab[cmd_slot] = cmd_arg_i;
							end
						end
						cal_table_pkg::cmd_offset: begin
							if (cmd_query_i) begin
								next_resp_valid = 1'b1;
								next_resp_data = {{16{off_tab[cmd_slot][15]}},
									off_tab[cmd_slot]};
							end else if (cal_mode) begin
								next_off_tab[cmd_slot] = cmd_arg_i[15:0];
							end
						end
						default: begin
						end
					endcase
				end
			end
			st_load: begin
				// One word per flash acknowledge
				if (flash_ack_i) begin
					next_gain_tab[idx] = flash_rdata_i[47:16];
					next_off_tab[idx] = flash_rdata_i[15:0];
					if (idx == 5'(ENTRIES - 1)) begin
						next_state = st_idle;
						next_cal_mode = 1'b1;
					end else begin
						next_idx = idx + 5'h01;
					end
				end
			end
			st_save: begin
				// Every channel is written back
				if (flash_ack_i) begin
					if (idx == 5'(ENTRIES - 1)) next_state = st_idle;
					else next_idx = idx + 5'h01;
				end
			end
			default: next_state = st_idle;
		endcase
	end

	// State registers; table holds nominal values until first load
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= st_idle;
			cal_mode <= 1'b0;
			idx <= 5'h00;
			resp_valid_o <= 1'b0;
			resp_data_o <= 32'h0000_0000;
			for (int i = 0; i < ENTRIES; i++) begin
				gain_tab[i] <= cal_table_pkg::GAIN_NOMINAL;
				off_tab[i] <= cal_table_pkg::OFFSET_RESET;
			end
			for (int c = 0; c < CHANNELS; c++)
				sel_type[c] <= cal_table_pkg::TYPE_RESET;
		end else begin
			state <= next_state;
			cal_mode <= next_cal_mode;
			idx <= next_idx;
			resp_valid_o <= next_resp_valid;
			resp_data_o <= next_resp_data;
			gain_tab <= next_gain_tab;
			off_tab <= next_off_tab;
			sel_type <= next_sel_type;
		end
	end

	// Flash strobes held until acknowledged
	assign cal_mode_o = cal_mode;
	assign busy_o = (state != st_idle);
	assign flash_rd_o = (state == st_load);
	assign flash_wr_o = (state == st_save); // Only reached from save
	assign flash_addr_o = idx;
	assign flash_wdata_o = {gain_tab[idx], off_tab[idx]};

	logic corr_valid;
	logic signed [SAMPLE_W-1:0] corr;
	// Correction from RAM table; outside the mode the sample passes raw
	cal_corrector #(
		.SAMPLE_W(SAMPLE_W),
		.OFFSET_W(OFFSET_W)
	) u_corr (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.sample_valid_i(sample_valid_i),
		.sample_i(sample_i),
		.offset_i(cal_mode ? off_tab[smp_slot][OFFSET_W-1:0]
			: OFFSET_W'(0)),
		.gain_q_i(cal_mode ? gain_q(gain_tab[smp_slot]) : 18'h10000),
		.corr_valid_o(corr_valid),
		.corr_o(corr)
	);
	assign corr_valid_o = corr_valid;
	assign corr_o = corr;
endmodule : input_calibration_table_manager
`default_nettype wire

// ### hw/cal_table_pkg.sv
// Constants and types for the input calibration table manager.
// Assumes a single 20 MHz clock domain; used by hw/ design files only.
package cal_table_pkg;
	// Command codes on the command port
	typedef enum logic [2:0] {
		cmd_mode = 3'h0,
		cmd_save = 3'h1,
		cmd_type = 3'h2,
		cmd_gain = 3'h3,
		cmd_offset = 3'h4
	} cmd_t;
	// Calibration types
	typedef enum logic [2:0] {
		voltage_cal_type = 3'h0,
		current_source_cal_type = 3'h1,
		low_resistance_cal_type = 3'h2,
		mid_resistance_cal_type = 3'h3,
		high_resistance_cal_type = 3'h4
	} cal_type_t;
	localparam int unsigned NUM_TYPES = 5;
	localparam int unsigned NUM_CHANNELS = 4;
	// IEEE-754 single precision 1.0 as the nominal gain
	localparam logic [31:0] GAIN_NOMINAL = 32'h3f80_0000;
	localparam logic [15:0] OFFSET_RESET = 16'h0000;
	localparam logic [2:0] TYPE_RESET = 3'h0;
endpackage : cal_table_pkg

// ### hw/cal_corrector.sv
// Applies offset and gain correction to one raw converter sample.
// Assumes gain is passed as a fixed-point Q2.16 approximation by caller.
`timescale 1ns/1ps
`default_nettype none
module cal_corrector #(
	parameter int unsigned SAMPLE_W = 24,
	parameter int unsigned OFFSET_W = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic sample_valid_i,
	input wire logic signed [SAMPLE_W-1:0] sample_i,
	input wire logic signed [OFFSET_W-1:0] offset_i,
	input wire logic [17:0] gain_q_i,
	output logic corr_valid_o,
	output logic signed [SAMPLE_W-1:0] corr_o
);
	initial begin
		if (OFFSET_W > SAMPLE_W) $error("offset wider than sample");
	end
	logic signed [SAMPLE_W:0] shifted;
	logic signed [SAMPLE_W+19:0] product;
	logic next_valid;
	logic signed [SAMPLE_W-1:0] next_corr;
	// Offset first, then gain; product truncated back to sample width
	always_comb begin
		shifted = $signed({sample_i[SAMPLE_W-1], sample_i})
			- $signed({{(SAMPLE_W+1-OFFSET_W){offset_i[OFFSET_W-1]}},
			offset_i});
		product = shifted * $signed({2'b00, gain_q_i});
		next_valid = sample_valid_i;
		next_corr = sample_valid_i ? product[SAMPLE_W+15:16] : corr_o;
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			corr_valid_o <= 1'b0;
			corr_o <= '0;
		end else begin
			corr_valid_o <= next_valid;
			corr_o <= next_corr;
		end
	end
endmodule : cal_corrector
`default_nettype wire

// ### test/flash_model.sv
// Behavioural flash table behind the manager's word port.
// Assumes rd/wr and address are held until each ack.
`timescale 1ns/1ps
`default_nettype none
module flash_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [4:0] addr_i,
	input wire logic [47:0] wdata_i,
	output logic [47:0] rdata_o,
	output logic ack_o
);
	logic [47:0] mem [20];
	logic [1:0] cnt;
	// Odd words answer slowly, even words at once
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'b0;
			cnt <= 2'h0;
			for (int i = 0; i < 20; i++)
				mem[i] <= {32'h3f80_0000 + 32'(i), 16'(i)};
		end else if ((rd_i || wr_i) && !ack_o && cnt >= {addr_i[0], 1'b0}) begin
			ack_o <= 1'b1;
			cnt <= 2'h0;
			if (wr_i)
				mem[addr_i] <= wdata_i;
		end else begin
			ack_o <= 1'b0;
			cnt <= ((rd_i || wr_i) && !ack_o) ? cnt + 2'h1 : 2'h0;
		end
	end
	// Outside an ack the lines carry junk, so stale data cannot pass
	assign rdata_o = ack_o ? mem[addr_i] : ~mem[addr_i];
endmodule : flash_model
`default_nettype wire

// ### test/input_calibration_table_manager_chk.sv
// Port checker for the calibration table manager.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module cal_mgr_chk #(
	parameter int unsigned SAMPLE_W = 24
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire logic [2:0] cmd_code_i,
	input wire logic cmd_query_i,
	input wire logic [31:0] cmd_arg_i,
	input wire logic resp_valid_o,
	input wire logic cal_mode_o,
	input wire logic busy_o,
	input wire logic flash_rd_o,
	input wire logic flash_wr_o,
	input wire logic [4:0] flash_addr_o,
	input wire logic flash_ack_i,
	input wire logic sample_valid_i,
	input wire logic signed [SAMPLE_W-1:0] sample_i,
	input wire logic corr_valid_o,
	input wire logic signed [SAMPLE_W-1:0] corr_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Accepted commands
	logic tk;
	logic tq;
	assign tk = cmd_valid_i && cmd_ready_o && !cmd_query_i;
	assign tq = cmd_valid_i && cmd_ready_o && cmd_query_i;
	AST_RESP: assert property (
		tq |=> resp_valid_o) else $error("query not answered");
	AST_LOAD: assert property (
		tk && cmd_code_i == 3'h0 && cmd_arg_i[0] && !cal_mode_o |=>
		busy_o && flash_rd_o && flash_addr_o == 5'h00)
		else $error("load not started");
	AST_DONE: assert property (
		flash_rd_o && flash_ack_i && flash_addr_o == 5'h13 |=>
		!busy_o && cal_mode_o) else $error("load end wrong");
	AST_STEP: assert property (
		(flash_rd_o || flash_wr_o) && flash_ack_i && flash_addr_o != 5'h13
		|=> flash_addr_o == $past(flash_addr_o) + 5'h01)
		else $error("address not stepped");
	AST_SAVE: assert property (
		tk && cmd_code_i == 3'h1 && cal_mode_o |=>
		flash_wr_o && flash_addr_o == 5'h00) else $error("save not started");
	AST_NOSAVE: assert property (
		tk && cmd_code_i == 3'h1 && !cal_mode_o |=> !busy_o)
		else $error("save acted outside mode");
	AST_WR: assert property (
		flash_wr_o |-> cal_mode_o) else $error("flash written outside mode");
	AST_OFF: assert property (
		tk && cmd_code_i == 3'h0 && !cmd_arg_i[0] |=>
		!cal_mode_o && !flash_wr_o) else $error("mode off wrong");
	AST_CORR: assert property (
		sample_valid_i |=> corr_valid_o) else $error("no corrected sample");
	AST_RAW: assert property (
		sample_valid_i && !cal_mode_o |=> corr_o == $past(sample_i))
		else $error("raw sample altered");
endmodule : cal_mgr_chk
bind input_calibration_table_manager cal_mgr_chk #(.SAMPLE_W(SAMPLE_W)) chk (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
	.cmd_ready_o(cmd_ready_o), .cmd_code_i(cmd_code_i),
	.cmd_query_i(cmd_query_i), .cmd_arg_i(cmd_arg_i),
	.resp_valid_o(resp_valid_o), .cal_mode_o(cal_mode_o), .busy_o(busy_o),
	.flash_rd_o(flash_rd_o), .flash_wr_o(flash_wr_o),
	.flash_addr_o(flash_addr_o), .flash_ack_i(flash_ack_i),
	.sample_valid_i(sample_valid_i), .sample_i(sample_i),
	.corr_valid_o(corr_valid_o), .corr_o(corr_o));
`default_nettype wire

// ### test/input_calibration_table_manager_tb.sv
// Self-checking bench for the calibration table manager.
// Assumes the flash model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module input_calibration_table_manager_tb;
	logic clk = 1'b0, rst_n = 1'b0, cv = 1'b0, cq = 1'b0, sv = 1'b0;
	logic cr, rv, cm, bz, frd, fwr, fack, corr_v;
	logic [2:0] cc = 3'h0;
	logic [1:0] ch = 2'h0, sch = 2'h0;
	logic [31:0] ca = 32'h0, rd, s32 = 32'h0000_fe18;
	logic [4:0] fa;
	logic [47:0] fwd, frdat;
	logic signed [23:0] smp = 24'h0, corr;
	logic [31:0] g [4][5], o [4][5];
	int error_cnt = 0, tests_run = 0, cyc = 0;
	always #25 clk = ~clk;
	input_calibration_table_manager uut (.ref_clk_i(clk), .rst_n_i(rst_n),
		.cmd_valid_i(cv), .cmd_ready_o(cr), .cmd_code_i(cc), .cmd_query_i(cq),
		.cmd_chan_i(ch), .cmd_arg_i(ca), .resp_valid_o(rv), .resp_data_o(rd),
		.cal_mode_o(cm), .busy_o(bz), .flash_rd_o(frd), .flash_wr_o(fwr),
		.flash_addr_o(fa), .flash_wdata_o(fwd), .flash_rdata_i(frdat),
		.flash_ack_i(fack), .sample_valid_i(sv), .sample_chan_i(sch),
		.sample_i(smp), .corr_valid_o(corr_v), .corr_o(corr));
	flash_model fm (.clk_i(clk), .rst_n_i(rst_n), .rd_i(frd), .wr_i(fwr),
		.addr_i(fa), .wdata_i(fwd), .rdata_o(frdat), .ack_o(fack));
	function automatic logic [31:0] rnd();
		s32 ^= s32 << 13;
		s32 ^= s32 >> 17;
		s32 ^= s32 << 5;
		return s32;
	endfunction : rnd
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("errors %0d, checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	// One command from idle; a spare edge keeps valid from toggling twice
	task automatic cmd(input logic [2:0] c, input logic q,
		input logic [1:0] h, input logic [31:0] a);
		do @(posedge clk) #1; while (cr !== 1'b1);
		{cv, cc, cq, ch, ca} = {1'b1, c, q, h, a};
		@(posedge clk) #1;
		cv = 1'b0;
	endtask : cmd
	task automatic ask(input logic [2:0] c, input logic [1:0] h,
		input logic [31:0] exp);
		cmd(c, 1'b1, h, 32'h0);
		check({31'h0, rv}, 32'h1);
		check(rd, exp);
	endtask : ask
	task automatic samp(input logic [1:0] h, input logic [23:0] s,
		input logic [23:0] exp);
		@(posedge clk) #1;
		{sv, sch, smp} = {1'b1, h, s};
		@(posedge clk) #1;
		sv = 1'b0;
		check({8'h0, corr}, {8'h0, exp});
	endtask : samp
	initial begin
		logic [31:0] v;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		ask(3'h0, 2'h2, 32'h0);
		ask(3'h3, 2'h1, 32'h3f80_0000);
		cmd(3'h2, 1'b0, 2'h1, 32'h3);
		ask(3'h2, 2'h1, 32'h0);
		cmd(3'h1, 1'b0, 2'h0, 32'h0);
		check({31'h0, bz}, 32'h0);
		samp(2'h1, 24'h123456, 24'h123456);
		cmd(3'h0, 1'b0, 2'(rnd()), 32'h1);
		ask(3'h0, 2'h1, 32'h1);
		for (int c = 0; c < 4; c++)
			for (int t = 0; t < 5; t++) begin
				cmd(3'h2, 1'b0, 2'(c), 32'(t));
				cmd(3'h2, 1'b0, 2'(c), 32'h7);
				// High bits set: must not alias a valid type code
				cmd(3'h2, 1'b0, 2'(c), 32'h8 + 32'((t + 1) % 5));
				ask(3'h2, 2'(c), 32'(t));
				ask(3'h3, 2'(c), 32'h3f80_0000 + 32'(c * 5 + t));
				ask(3'h4, 2'(c), 32'(c * 5 + t));
				g[c][t] = rnd();
				v = rnd();
				o[c][t] = {{16{v[15]}}, v[15:0]};
				cmd(3'h3, 1'b0, 2'(c), g[c][t]);
				cmd(3'h4, 1'b0, 2'(c), v);
				ask(3'h3, 2'(c), g[c][t]);
				ask(3'h4, 2'(c), o[c][t]);
			end
		cmd(3'h2, 1'b0, 2'h2, 32'h0);
		ask(3'h3, 2'h2, g[2][0]);
		// Unity gain so the expected correction is a plain subtraction
		cmd(3'h2, 1'b0, 2'h0, 32'h0);
		g[0][0] = 32'h3f80_0000;
		o[0][0] = 32'h5;
		cmd(3'h3, 1'b0, 2'h0, g[0][0]);
		cmd(3'h4, 1'b0, 2'h0, 32'h5);
		v = rnd();
		samp(2'h0, 24'(v[19:0]), 24'(v[19:0]) - 24'h5);
		cmd(3'h1, 1'b0, 2'(rnd()), 32'h0);
		while (bz === 1'b1)
			@(posedge clk) #1;
		for (int i = 0; i < 20; i++) begin
			check(fm.mem[i][47:16], g[i / 5][i % 5]);
			check(32'(fm.mem[i][15:0]), 32'(o[i / 5][i % 5][15:0]));
		end
		// Gain of two doubles the offset-corrected sample
		g[0][0] = 32'h4000_0000;
		cmd(3'h3, 1'b0, 2'h0, g[0][0]);
		samp(2'h0, 24'h00_0100, 24'h00_01f6);
		cmd(3'h0, 1'b0, 2'h3, 32'h0);
		ask(3'h0, 2'h0, 32'h0);
		cmd(3'h3, 1'b0, 2'h0, 32'h0);
		ask(3'h3, 2'h0, g[0][0]);
		samp(2'h0, 24'h7, 24'h7);
		stop_test();
	end
	// Hang guard, far above the several hundred cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			stop_test();
		end
	end
endmodule : input_calibration_table_manager_tb
`default_nettype wire
